// [rtl/nocr_pkg.sv]
// types of the offload configuration register bank
package nocr_pkg;
	typedef enum logic [3:0] {
		NOCR_PROTO_CLOSED = 4'h0,
		NOCR_PROTO_TCP = 4'h1,
		NOCR_PROTO_UDP = 4'h2,
		NOCR_PROTO_RAW_IP = 4'h3,
		NOCR_PROTO_RAW_ETH = 4'h4,
		NOCR_PROTO_PPPOE = 4'h5
	} nocr_proto_t;
	typedef logic [7:0] nocr_byte_t;
endpackage : nocr_pkg

// [rtl/nocr_regbank.sv]
// configuration register bank of the network offload engine
`timescale 1ns/1ps
`default_nettype none
`include "nocr_regs.svh"
module nocr_regbank (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] interrupt_cause_flags_i,
	output logic int_n_o,
	input wire logic auth_valid_i,
	input wire logic [15:0] auth_kind_i,
	input wire logic unreach_valid_i,
	input wire logic [31:0] unreach_ip_i,
	input wire logic [15:0] unreach_port_i,
	input wire logic [3:0] retry_event_i,
	input wire logic [3:0] retry_clear_i,
	output logic [3:0] retry_resend_o,
	output logic [3:0] socket_timeout_o,
	output logic retry_tick_o,
	output logic echo_request_o,
	output logic [7:0] lcp_magic_value_o,
	output logic [15:0] rx_base_kb_o [4],
	output logic [15:0] rx_size_kb_o [4],
	output logic [15:0] tx_base_kb_o [4],
	output logic [15:0] tx_size_kb_o [4],
	output var nocr_pkg::nocr_proto_t sock_proto_o [4],
	output logic [3:0] sock_multicast_o,
	output logic [3:0] sock_ack_every_o,
	output logic [3:0] sock_igmp_v1_o
);
	import nocr_pkg::*;

	logic [7:0] int_mask_reg, int_mask_next;
	logic [15:0] retry_ivl_reg, retry_ivl_next;
	logic [7:0] retry_limit_reg, retry_limit_next;
	logic [7:0] rx_split_reg, rx_split_next;
	logic [7:0] tx_split_reg, tx_split_next;
	logic [15:0] auth_reg, auth_next;
	logic [7:0] echo_ivl_reg, echo_ivl_next;
	logic [7:0] magic_reg, magic_next;
	logic [31:0] uip_reg, uip_next;
	logic [15:0] unr_port_reg, unr_port_next;
	logic [7:0] mode_reg [4];
	logic [7:0] mode_next [4];
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] cause_meta_reg, cause_sync_reg;
	logic int_n_reg, int_n_next;
	logic [13:0] rtick_cnt_reg, rtick_cnt_next;
	logic [15:0] rivl_cnt_reg, rivl_cnt_next;
	logic rtick_reg, rtick_next;
	logic [21:0] etick_cnt_reg, etick_cnt_next;
	logic [7:0] eivl_cnt_reg, eivl_cnt_next;
	logic echo_reg, echo_next;
	logic [7:0] retries_reg [4];
	logic [7:0] retries_next [4];
	logic [3:0] tmo_reg, tmo_next;
	logic [3:0] resend_reg, resend_next;

	localparam logic [13:0] RTICK_LAST = 14'(`NOCR_RETRY_TICK_CYC - 1);
	localparam logic [21:0] ETICK_LAST = 22'(`NOCR_ECHO_TICK_CYC - 1);

	// cause flags come from another block; two-stage capture
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cause_meta_reg <= 8'h00;
			cause_sync_reg <= 8'h00;
		end else begin
			cause_meta_reg <= interrupt_cause_flags_i;
			cause_sync_reg <= cause_meta_reg;
		end
	end

	// register writes and captures
	always_comb begin
		int_mask_next = int_mask_reg;
		retry_ivl_next = retry_ivl_reg;
		retry_limit_next = retry_limit_reg;
		rx_split_next = rx_split_reg;
		tx_split_next = tx_split_reg;
		auth_next = auth_reg;
		echo_ivl_next = echo_ivl_reg;
		magic_next = magic_reg;
		uip_next = uip_reg;
		unr_port_next = unr_port_reg;
		mode_next = mode_reg;
		if (auth_valid_i) begin
			auth_next = auth_kind_i;
		end
		if (unreach_valid_i) begin
			uip_next = unreach_ip_i;
			unr_port_next = unreach_port_i;
		end
		if (wr_i) begin
			case (addr_i)
				`NOCR_OFS_INT_MASK: begin
					int_mask_next = wdata_i & `NOCR_INT_MASK_VALID;
				end
				`NOCR_OFS_RETRY_IVL_HI: begin
					retry_ivl_next[15:8] = wdata_i;
				end
				`NOCR_OFS_RETRY_IVL_LO: begin
					retry_ivl_next[7:0] = wdata_i;
				end
				`NOCR_OFS_RETRY_LIMIT: begin
					retry_limit_next = wdata_i;
				end
				`NOCR_OFS_RX_SPLIT: begin
					rx_split_next = wdata_i;
				end
				`NOCR_OFS_TX_SPLIT: begin
					tx_split_next = wdata_i;
				end
				`NOCR_OFS_ECHO_IVL: begin
					echo_ivl_next = wdata_i;
				end
				`NOCR_OFS_MAGIC: begin
					magic_next = wdata_i;
				end
				default: begin
					for (int s = 0; s < 4; s++) begin
						if (addr_i == (`NOCR_OFS_SOCK_MODE0 + 16'(s << `NOCR_SOCK_STRIDE_SHIFT))) begin
							mode_next[s] = wdata_i & `NOCR_MODE_VALID;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_mask_reg <= `NOCR_RST_INT_MASK;
			retry_ivl_reg <= `NOCR_RST_RETRY_IVL;
			retry_limit_reg <= `NOCR_RST_RETRY_LIMIT;
			rx_split_reg <= `NOCR_RST_SPLIT;
			tx_split_reg <= `NOCR_RST_SPLIT;
			auth_reg <= 16'h0000;
			echo_ivl_reg <= `NOCR_RST_ECHO_IVL;
			magic_reg <= `NOCR_RST_MAGIC;
			uip_reg <= 32'h0000_0000;
			unr_port_reg <= 16'h0000;
			for (int s = 0; s < 4; s++) begin
				mode_reg[s] <= `NOCR_RST_MODE;
			end
		end else begin
			int_mask_reg <= int_mask_next;
			retry_ivl_reg <= retry_ivl_next;
			retry_limit_reg <= retry_limit_next;
			rx_split_reg <= rx_split_next;
			tx_split_reg <= tx_split_next;
			auth_reg <= auth_next;
			echo_ivl_reg <= echo_ivl_next;
			magic_reg <= magic_next;
			uip_reg <= uip_next;
			unr_port_reg <= unr_port_next;
			mode_reg <= mode_next;
		end
	end

	// read mux, big-endian byte order
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_i) begin
			case (addr_i)
				`NOCR_OFS_INT_MASK: rdata_next = int_mask_reg;
				`NOCR_OFS_RETRY_IVL_HI: rdata_next = retry_ivl_reg[15:8];
				`NOCR_OFS_RETRY_IVL_LO: rdata_next = retry_ivl_reg[7:0];
				`NOCR_OFS_RETRY_LIMIT: rdata_next = retry_limit_reg;
				`NOCR_OFS_RX_SPLIT: rdata_next = rx_split_reg;
				`NOCR_OFS_TX_SPLIT: rdata_next = tx_split_reg;
				`NOCR_OFS_AUTH_HI: rdata_next = auth_reg[15:8];
				`NOCR_OFS_AUTH_LO: rdata_next = auth_reg[7:0];
				`NOCR_OFS_ECHO_IVL: rdata_next = echo_ivl_reg;
				`NOCR_OFS_MAGIC: rdata_next = magic_reg;
				`NOCR_OFS_UIP0: rdata_next = uip_reg[31:24];
				`NOCR_OFS_UIP1: rdata_next = uip_reg[23:16];
				`NOCR_OFS_UIP2: rdata_next = uip_reg[15:8];
				`NOCR_OFS_UIP3: rdata_next = uip_reg[7:0];
				`NOCR_OFS_UNR_PORT_HI: rdata_next = unr_port_reg[15:8];
				`NOCR_OFS_UNR_PORT_LO: rdata_next = unr_port_reg[7:0];
				default: begin
					rdata_next = 8'h00;
					for (int s = 0; s < 4; s++) begin
						if (addr_i == (`NOCR_OFS_SOCK_MODE0 + 16'(s << `NOCR_SOCK_STRIDE_SHIFT))) begin
							rdata_next = mode_reg[s];
						end
					end
				end
			endcase
		end
	end

	// interrupt level from enabled causes
	always_comb begin
		int_n_next = ~|(cause_sync_reg & int_mask_reg & `NOCR_INT_MASK_VALID);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 8'h00;
			int_n_reg <= 1'b1;
		end else begin
			rdata_reg <= rdata_next;
			int_n_reg <= int_n_next;
		end
	end

	// retry timer and per-socket retry counting
	always_comb begin
		rtick_cnt_next = rtick_cnt_reg + 14'h0001;
		rtick_next = 1'b0;
		rivl_cnt_next = rivl_cnt_reg;
		retries_next = retries_reg;
		tmo_next = 4'h0;
		resend_next = 4'h0;
		if (rtick_cnt_reg == RTICK_LAST) begin
			rtick_cnt_next = 14'h0000;
			rivl_cnt_next = rivl_cnt_reg + 16'h0001;
			if (rivl_cnt_reg + 16'h0001 >= retry_ivl_reg) begin
				rivl_cnt_next = 16'h0000;
				rtick_next = 1'b1;
			end
		end
		for (int s = 0; s < 4; s++) begin
			if (retry_clear_i[s]) begin
				retries_next[s] = 8'h00;
			end else if (rtick_reg && retry_event_i[s]) begin
				if (retries_reg[s] >= retry_limit_reg) begin
					tmo_next[s] = 1'b1;
					retries_next[s] = 8'h00;
				end else begin
					resend_next[s] = 1'b1;
					retries_next[s] = retries_reg[s] + 8'h01;
				end
			end
		end
	end

	// lcp echo timer
	always_comb begin
		etick_cnt_next = etick_cnt_reg + 22'h000001;
		eivl_cnt_next = eivl_cnt_reg;
		echo_next = 1'b0;
		if (mode_reg[0][3:0] != NOCR_PROTO_PPPOE) begin
			etick_cnt_next = 22'h000000;
			eivl_cnt_next = 8'h00;
		end else if (etick_cnt_reg == ETICK_LAST) begin
			etick_cnt_next = 22'h000000;
			eivl_cnt_next = eivl_cnt_reg + 8'h01;
			if (eivl_cnt_reg + 8'h01 >= echo_ivl_reg) begin
				eivl_cnt_next = 8'h00;
				echo_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rtick_cnt_reg <= 14'h0000;
			rivl_cnt_reg <= 16'h0000;
			rtick_reg <= 1'b0;
			etick_cnt_reg <= 22'h000000;
			eivl_cnt_reg <= 8'h00;
			echo_reg <= 1'b0;
			tmo_reg <= 4'h0;
			resend_reg <= 4'h0;
			for (int s = 0; s < 4; s++) begin
				retries_reg[s] <= 8'h00;
			end
		end else begin
			rtick_cnt_reg <= rtick_cnt_next;
			rivl_cnt_reg <= rivl_cnt_next;
			rtick_reg <= rtick_next;
			etick_cnt_reg <= etick_cnt_next;
			eivl_cnt_reg <= eivl_cnt_next;
			echo_reg <= echo_next;
			tmo_reg <= tmo_next;
			resend_reg <= resend_next;
			retries_reg <= retries_next;
		end
	end

	// buffer split decode, allocation in socket order
	always_comb begin
		logic [15:0] rx_used;
		logic [15:0] tx_used;
		logic [15:0] want;
		rx_used = 16'h0000;
		tx_used = 16'h0000;
		want = 16'h0000;
		for (int s = 0; s < 4; s++) begin
			want = 16'h0001 << rx_split_reg[2*s +: 2];
			rx_base_kb_o[s] = rx_used;
			rx_size_kb_o[s] = 16'h0000;
			if (rx_used + want <= 16'(`NOCR_TOTAL_KB)) begin
				rx_size_kb_o[s] = want;
				rx_used = rx_used + want;
			end
			want = 16'h0001 << tx_split_reg[2*s +: 2];
			tx_base_kb_o[s] = tx_used;
			tx_size_kb_o[s] = 16'h0000;
			if (tx_used + want <= 16'(`NOCR_TOTAL_KB)) begin
				tx_size_kb_o[s] = want;
				tx_used = tx_used + want;
			end
		end
	end

	// socket mode decode
	always_comb begin
		for (int s = 0; s < 4; s++) begin
			case (mode_reg[s][3:0])
				4'h1: sock_proto_o[s] = NOCR_PROTO_TCP;
				4'h2: sock_proto_o[s] = NOCR_PROTO_UDP;
				4'h3: sock_proto_o[s] = NOCR_PROTO_RAW_IP;
				4'h4: sock_proto_o[s] = (s == 0) ? NOCR_PROTO_RAW_ETH : NOCR_PROTO_CLOSED;
				4'h5: sock_proto_o[s] = (s == 0) ? NOCR_PROTO_PPPOE : NOCR_PROTO_CLOSED;
				default: sock_proto_o[s] = NOCR_PROTO_CLOSED;
			endcase
			sock_multicast_o[s] = mode_reg[s][`NOCR_MODE_MULTI_BIT]
				&& (mode_reg[s][3:0] == 4'h2);
			sock_ack_every_o[s] = mode_reg[s][`NOCR_MODE_ACK_BIT]
				&& (mode_reg[s][3:0] == 4'h1);
			sock_igmp_v1_o[s] = sock_multicast_o[s] && mode_reg[s][`NOCR_MODE_ACK_BIT];
		end
	end

	assign rdata_o = rdata_reg;
	assign int_n_o = int_n_reg;
	assign retry_resend_o = resend_reg;
	assign socket_timeout_o = tmo_reg;
	assign retry_tick_o = rtick_reg;
	assign echo_request_o = echo_reg;
	assign lcp_magic_value_o = magic_reg;

	a_int_follows_mask: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		int_n_o == ~|($past(cause_sync_reg) & $past(int_mask_reg)))
		else $error("interrupt level disagrees with enabled causes");
	a_int_held_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(|(cause_sync_reg & int_mask_reg)) |=> !int_n_o)
		else $error("interrupt released while enabled cause set");
	a_mask_bit4_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(rd_i && addr_i == `NOCR_OFS_INT_MASK) |=> !rdata_o[4])
		else $error("reserved mask bit read back set");
	a_mode_resv_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		((mode_reg[0] | mode_reg[1] | mode_reg[2] | mode_reg[3]) & ~`NOCR_MODE_VALID) == 8'h00)
		else $error("reserved mode bit set");
	a_retry_hi_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr_i && addr_i == `NOCR_OFS_RETRY_IVL_HI) |=> retry_ivl_reg[15:8] == $past(wdata_i))
		else $error("retry interval high byte not written");
	a_unreach_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		unreach_valid_i |=> (uip_reg == $past(unreach_ip_i))
		&& (unr_port_reg == $past(unreach_port_i)))
		else $error("unreachable capture missed");
	a_split_total: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(rx_size_kb_o[0] + rx_size_kb_o[1] + rx_size_kb_o[2] + rx_size_kb_o[3]) <= 16'h0008)
		else $error("rx allocation over total");
	a_sock1_no_raw_eth: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(mode_reg[1][3:0] == 4'h4) |-> sock_proto_o[1] == NOCR_PROTO_CLOSED)
		else $error("raw ethernet accepted on socket 1");
	a_timeout_on_limit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(rtick_reg && retry_event_i[0] && !retry_clear_i[0] && retries_reg[0] >= retry_limit_reg)
		|=> socket_timeout_o[0])
		else $error("timeout not raised at retry limit");
	a_mcast_udp_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		sock_multicast_o[2] |-> mode_reg[2][3:0] == 4'h2)
		else $error("multicast outside udp");
endmodule : nocr_regbank
`default_nettype wire

// [rtl/nocr_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef NOCR_REGS_SVH
`define NOCR_REGS_SVH
`define NOCR_OFS_INT_MASK 16'h0016
`define NOCR_OFS_RETRY_IVL_HI 16'h0017
`define NOCR_OFS_RETRY_IVL_LO 16'h0018
`define NOCR_OFS_RETRY_LIMIT 16'h0019
`define NOCR_OFS_RX_SPLIT 16'h001A
`define NOCR_OFS_TX_SPLIT 16'h001B
`define NOCR_OFS_AUTH_HI 16'h001C
`define NOCR_OFS_AUTH_LO 16'h001D
`define NOCR_OFS_ECHO_IVL 16'h0028
`define NOCR_OFS_MAGIC 16'h0029
`define NOCR_OFS_UIP0 16'h002A
`define NOCR_OFS_UIP1 16'h002B
`define NOCR_OFS_UIP2 16'h002C
`define NOCR_OFS_UIP3 16'h002D
`define NOCR_OFS_UNR_PORT_HI 16'h002E
`define NOCR_OFS_UNR_PORT_LO 16'h002F
`define NOCR_OFS_SOCK_MODE0 16'h0400
`define NOCR_SOCK_STRIDE_SHIFT 8
`define NOCR_RST_INT_MASK 8'h00
`define NOCR_RST_RETRY_IVL 16'h07D0
`define NOCR_RST_RETRY_LIMIT 8'h08
`define NOCR_RST_SPLIT 8'h55
`define NOCR_RST_ECHO_IVL 8'h28
`define NOCR_RST_MAGIC 8'h00
`define NOCR_RST_MODE 8'h00
`define NOCR_INT_MASK_VALID 8'hEF
`define NOCR_MODE_VALID 8'hAF
`define NOCR_MODE_MULTI_BIT 7
`define NOCR_MODE_ACK_BIT 5
`define NOCR_AUTH_PAP 16'hC023
`define NOCR_AUTH_CHAP 16'hC223
`define NOCR_RETRY_TICK_US 100
`define NOCR_CLK_MHZ 100
`define NOCR_RETRY_TICK_CYC ((`NOCR_RETRY_TICK_US) * (`NOCR_CLK_MHZ))
`define NOCR_ECHO_TICK_MS 25
`define NOCR_ECHO_TICK_CYC ((`NOCR_ECHO_TICK_MS) * 1000 * (`NOCR_CLK_MHZ))
`define NOCR_TOTAL_KB 8
`endif

// [sim/nocr_host_model.sv]
// host processor model driving the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module nocr_host_model (
	input wire logic clk_i,
	output logic [15:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	logic break_rules;
	initial begin
		break_rules = 1'b0;
		addr_o = 16'hFFFF;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// one byte write, entered just after a rising edge
	task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
		addr_o = a;
		wdata_o = (a == 16'h0016 && !break_rules) ? (d & 8'hEF) : d;
		wr_o = 1'b1;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~wdata_o;
		@(posedge clk_i);
		#1;
	endtask : wr_byte
	// one byte read, data taken after the edge that accepts it
	task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
		@(posedge clk_i);
		#1;
	endtask : rd_byte
endmodule : nocr_host_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench of the offload configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
	import nocr_pkg::*;
	localparam logic [24*20-1:0] RT = {24'h001600, 24'h001707, 24'h0018D0, 24'h001908,
		24'h001A55, 24'h001B55, 24'h001C00, 24'h001D00, 24'h002828, 24'h002900, 24'h002A00,
		24'h002B00, 24'h002C00, 24'h002D00, 24'h002E00, 24'h002F00, 24'h040000, 24'h050000,
		24'h060000, 24'h070000};
	localparam logic [16*12-1:0] RW = {16'h0700, 16'h0600, 16'h0500, 16'h0400, 16'h0029,
		16'h0028, 16'h001B, 16'h001A, 16'h0019, 16'h0018, 16'h0017, 16'h0016};
	logic clk, rst_n, wr, rd, av, uv, int_n, tick, echo, eh;
	logic [15:0] addr, ak, up;
	logic [7:0] wd, rdat, cause, mg, v, d;
	logic [31:0] uip;
	logic [3:0] rev, rclr, rs, to, mc, ae, ig;
	logic [15:0] rxb [4], rxs [4], txb [4], txs [4];
	nocr_proto_t pr [4];
	int n_fail, checks_done, cyc, seed, i, s, n, m;
	nocr_host_model i_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wd),
		.rdata_i(rdat));
	nocr_regbank i_dut (.clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wr_i(wr), .rd_i(rd),
		.wdata_i(wd), .rdata_o(rdat), .interrupt_cause_flags_i(cause), .int_n_o(int_n),
		.auth_valid_i(av), .auth_kind_i(ak), .unreach_valid_i(uv), .unreach_ip_i(uip),
		.unreach_port_i(up), .retry_event_i(rev), .retry_clear_i(rclr),
		.retry_resend_o(rs), .socket_timeout_o(to), .retry_tick_o(tick),
		.echo_request_o(echo), .lcp_magic_value_o(mg), .rx_base_kb_o(rxb), .rx_size_kb_o(rxs),
		.tx_base_kb_o(txb), .tx_size_kb_o(txs), .sock_proto_o(pr), .sock_multicast_o(mc),
		.sock_ack_every_o(ae), .sock_igmp_v1_o(ig));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// {check, base, size} of socket k; check low where the split leaves it open
	function automatic logic [32:0] alloc(input logic [7:0] c, input int k);
		int used, sz, j;
		logic ok;
		used = 0;
		ok = 1'b1;
		for (j = 0; j < k; j++) begin
			sz = 1 << c[2*j +: 2];
			if (ok && used + sz <= 8) used += sz;
			else ok = 1'b0;
		end
		sz = 1 << c[2*k +: 2];
		if (ok && used + sz <= 8) return {1'b1, 16'(used), 16'(sz)};
		if (used == 8) return {1'b1, 16'(used), 16'h0000};
		return 33'h0;
	endfunction : alloc
	task automatic rd_chk(input logic [23:0] t);
		logic [7:0] g;
		i_host.rd_byte(t[23:8], g);
		`CHK("rdata", t[7:0], g)
	endtask : rd_chk
	task automatic chk_split(input logic [7:0] c);
		logic [32:0] e;
		logic [32:0] f;
		i_host.wr_byte(16'h001A, c);
		i_host.wr_byte(16'h001B, ~c);
		for (int k = 0; k < 4; k++) begin
			e = alloc(c, k);
			f = alloc(~c, k);
			if (e[32]) `CHK("rx_size", e[15:0], rxs[k])
			if (e[32] && e[15:0] != 0) `CHK("rx_base", e[31:16], rxb[k])
			if (f[32]) `CHK("tx_size", f[15:0], txs[k])
			if (f[32] && f[15:0] != 0) `CHK("tx_base", f[31:16], txb[k])
		end
	endtask : chk_split
	task automatic wait_tick();
		do begin
			@(posedge clk);
			#1;
		end while (tick !== 1'b1);
	endtask : wait_tick
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		seed = 32'h8E19;
		n_fail = 0;
		checks_done = 0;
		cyc = 0;
		rst_n = 1'b0;
		cause = 8'h00;
		av = 1'b0;
		uv = 1'b0;
		ak = 16'h0000;
		uip = 32'h0;
		up = 16'h0000;
		rev = 4'h0;
		rclr = 4'h0;
		eh = 1'b0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		for (i = 0; i < 20; i++) rd_chk(RT[i*24 +: 24]);
		`CHK("int_n", 1'b1, int_n)
		`CHK("rx_size0", 16'h0002, rxs[0])
		$display("test reset values done");
		i_host.break_rules = 1'b1;
		for (i = 0; i < 40; i++) begin
			n = $unsigned($random(seed)) % 12;
			v = 8'($random(seed));
			i_host.wr_byte(RW[n*16 +: 16], v);
			rd_chk({RW[n*16 +: 16], v & (n == 0 ? 8'hEF : n > 7 ? 8'hAF : 8'hFF)});
			if (n == 7) `CHK("magic", v, mg)
		end
		i_host.break_rules = 1'b0;
		i_host.wr_byte(16'h001C, 8'hFF);
		rd_chk({16'h001C, 8'h00});
		i_host.wr_byte(16'h0030, 8'hFF);
		rd_chk({16'h0030, 8'h00});
		$display("test register access done");
		for (i = 0; i < 24; i++) begin
			v = (i == 0) ? 8'hFF : 8'($random(seed));
			d = (i == 0) ? 8'h10 : 8'($random(seed));
			i_host.wr_byte(16'h0016, v);
			cause = d;
			repeat (4) @(posedge clk);
			#1 `CHK("int_n", ~|(d & v & 8'hEF), int_n)
		end
		cause = 8'h00;
		$display("test interrupt mask done");
		for (i = 0; i < 16; i++) chk_split(i < 4 ? 8'(32'hAAFF001B >> (i * 8)) : 8'($random(seed)));
		$display("test buffer split done");
		for (s = 0; s < 4; s++) begin
			for (i = 0; i < 24; i++) begin
				v = 8'($random(seed));
				v[3:0] = 4'(i % 6);
				i_host.wr_byte({6'h01, 2'(s), 8'h00}, v);
				d = (v[3:0] > 3 && s > 0) ? 8'h00 : {4'h0, v[3:0]};
				`CHK("proto", nocr_proto_t'(d[3:0]), pr[s])
				`CHK("multi", v[7] && d == 2, mc[s])
				`CHK("ack", v[5] && d == 1, ae[s])
				`CHK("igmp", v[5] && v[7] && d == 2, ig[s])
				rd_chk({6'h01, 2'(s), 8'h00, v & 8'hAF});
			end
		end
		$display("test socket mode done");
		for (i = 0; i < 8; i++) begin
			ak = i[0] ? 16'hC223 : 16'hC023;
			uip = $random(seed);
			up = 16'($random(seed));
			av = 1'b1;
			uv = 1'b1;
			@(posedge clk);
			#1 av = 1'b0;
			uv = 1'b0;
			ak = ~ak;
			uip = ~uip;
			up = ~up;
			rd_chk({16'h001C, ~ak[15:8]});
			rd_chk({16'h001D, ~ak[7:0]});
			for (n = 0; n < 4; n++) rd_chk({16'h002A + 16'(n), ~uip[31-8*n -: 8]});
			rd_chk({16'h002E, ~up[15:8]});
			rd_chk({16'h002F, ~up[7:0]});
		end
		$display("test capture done");
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		rd_chk({16'h001A, 8'h55});
		i_host.wr_byte(16'h0018, 8'h01);
		i_host.wr_byte(16'h0017, 8'h00);
		i_host.wr_byte(16'h0019, 8'h02);
		wait_tick();
		n = cyc;
		wait_tick();
		`CHK("tick_period", 10000, cyc - n)
		rev = 4'h3;
		rclr = 4'h2;
		eh = 1'b0;
		n = 0;
		m = 0;
		do begin
			@(posedge clk);
			#1;
			if (rs[0] === 1'b1) n++;
			if (rs[1] !== 1'b0 || to[1] !== 1'b0) m++;
			eh = eh | (echo !== 1'b0);
		end while (to[0] !== 1'b1);
		`CHK("resends", 2, n)
		`CHK("cleared_retries", 0, m)
		`CHK("echo_closed", 1'b0, eh)
		`CHK("timeout_other", 3'h0, to[3:1])
		rev = 4'h0;
		rclr = 4'h0;
		$display("test retry done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
